// [rtcc_pkg.sv]
// Purpose: constants for the byte-wide memory with calendar clock
// Assumes: single clock clk_sys at 125 MHz, host pins synchronous to it
// Notes:   clock locations are indexed 0..7 from the lowest of the top eight
//
// How it works
// - 32k x 8 array over byte-wide pins
// - top eight locations hold clock; rest storage
// - BCD century to seconds, 24-hour hours
// - month ends and leap days corrected automatically
// - visible copy separate; access never stalls counting
// - supply fault deselects, ignoring reads and writes
// - read-hold bit 6 stops visible updates
// - held copy frozen while counters keep running
// - hold release updates all registers together
// - set-hold bit 7 halts updates for loading
// - set-hold release loads counters, then resumes
// - chip select high: deselected, lines released
// - select and write strobe low: write
// - select, strobe high, output enable low: read
// - both enables high: read, lines released
// - clock at 7ff8..7fff, century first, year last
// - seconds bit 7 stops the oscillator
package rtcc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [14:0] CLOCK_BASE = 15'h7ff8;
  // register indices within the clock block
  localparam logic [2:0] IDX_CENTURY = 3'h0;
  localparam logic [2:0] IDX_SECONDS = 3'h1;
  localparam logic [2:0] IDX_MINUTES = 3'h2;
  localparam logic [2:0] IDX_HOURS   = 3'h3;
  localparam logic [2:0] IDX_DAY     = 3'h4;
  localparam logic [2:0] IDX_DATE    = 3'h5;
  localparam logic [2:0] IDX_MONTH   = 3'h6;
  localparam logic [2:0] IDX_YEAR    = 3'h7;
  // control bit positions
  localparam int SET_HOLD_BIT  = 7;
  localparam int READ_HOLD_BIT = 6;
  localparam int OSC_STOP_BIT  = 7;
  // bits owned by the counters in each location, year first
  localparam logic [63:0] COUNT_MASKS = 64'hff_1f_3f_07_3f_7f_7f_3f;
  // count limits in bcd
  localparam logic [7:0] SEC_MAX  = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX  = 8'h07;
  localparam logic [7:0] MON_MAX  = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] CENT_MAX = 8'h39;
  // reset values of the counters: century 20, day 1, date 1, month 1
  localparam logic [63:0] COUNT_RESET = 64'h00_01_01_01_00_00_00_20;
  // one second of timekeeping in clk_sys cycles
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_NS    = 8;
  localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_NS);
  typedef logic [7:0][7:0] rtcc_bytes_t;
endpackage

// [rtcc_counter.sv]
// Purpose: running bcd calendar counters behind the visible registers
// Assumes: tick is a one-cycle pulse per second
// Notes:   load has priority over tick
`timescale 1ns/1ps
`default_nettype none
module rtcc_counter (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               tick,
  input  wire logic               load,
  input  wire rtcc_pkg::rtcc_bytes_t load_val,
  output var  rtcc_pkg::rtcc_bytes_t count
);
  import rtcc_pkg::*;

  rtcc_bytes_t cnt_r;
  rtcc_bytes_t cnt_nxt;

  // bcd step; wraps to lo past hi
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    if (v >= hi) begin
      bcd_step = lo;
    end else if (v[3:0] >= 4'h9) begin
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last date of the month; every fourth year leaps, good up to 2100
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic [7:0] bin;
    bin = 8'(yr[7:4] * 4'd10) + {4'h0, yr[3:0]};
    unique case (mon)
      8'h02:                      month_end = (bin[1:0] == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  endfunction

  // ripple carry through the calendar fields
  always_comb begin
    logic carry;
    carry = 1'b0;
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val & COUNT_MASKS;
    end else if (tick) begin
      cnt_nxt[IDX_SECONDS] = bcd_step(cnt_r[IDX_SECONDS], SEC_MAX, 8'h00);
      carry = (cnt_r[IDX_SECONDS] >= SEC_MAX);
      if (carry) begin
        cnt_nxt[IDX_MINUTES] = bcd_step(cnt_r[IDX_MINUTES], SEC_MAX, 8'h00);
        carry = (cnt_r[IDX_MINUTES] >= SEC_MAX);
      end
      if (carry) begin
        cnt_nxt[IDX_HOURS] = bcd_step(cnt_r[IDX_HOURS], HOUR_MAX, 8'h00);
        carry = (cnt_r[IDX_HOURS] >= HOUR_MAX);
      end
      if (carry) begin
        cnt_nxt[IDX_DAY]  = bcd_step(cnt_r[IDX_DAY], DAY_MAX, 8'h01);
        cnt_nxt[IDX_DATE] = bcd_step(cnt_r[IDX_DATE], month_end(cnt_r[IDX_MONTH], cnt_r[IDX_YEAR]), 8'h01);
        carry = (cnt_r[IDX_DATE] >= month_end(cnt_r[IDX_MONTH], cnt_r[IDX_YEAR]));
      end
      if (carry) begin
        cnt_nxt[IDX_MONTH] = bcd_step(cnt_r[IDX_MONTH], MON_MAX, 8'h01);
        carry = (cnt_r[IDX_MONTH] >= MON_MAX);
      end
      if (carry) begin
        cnt_nxt[IDX_YEAR] = bcd_step(cnt_r[IDX_YEAR], YEAR_MAX, 8'h00);
        carry = (cnt_r[IDX_YEAR] >= YEAR_MAX);
      end
      if (carry) begin
        cnt_nxt[IDX_CENTURY] = bcd_step(cnt_r[IDX_CENTURY], CENT_MAX, 8'h00);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= COUNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
endmodule
`default_nettype wire

// [rtcc_top.sv]
// Purpose: 32k x 8 storage with a double-buffered bcd clock in the top eight bytes
// Assumes: host enables and address are synchronous to clk_sys
// Notes:   reads answer one cycle after the request, writes land every selected cycle the strobe is low
`timescale 1ns/1ps
`default_nettype none
module rtcc_top #(
  parameter int TICK_CYCLES = rtcc_pkg::SECOND_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic [rtcc_pkg::ADDR_W-1:0] address_lines,
  input  wire logic [rtcc_pkg::DATA_W-1:0] data_lines_in,
  output var  logic [rtcc_pkg::DATA_W-1:0] data_lines_out,
  output var  logic                       data_lines_oe,
  input  wire logic                       chip_enable_n,
  input  wire logic                       output_enable_n,
  input  wire logic                       write_enable_n,
  input  wire logic                       supply_ok,
  output var  logic                       osc_running
);
  import rtcc_pkg::*;

  // storage for the low locations; the top eight live in vis_r instead
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];

  rtcc_bytes_t       vis_r;
  rtcc_bytes_t       vis_nxt;
  rtcc_bytes_t       count;
  logic              set_hold_q_r;
  logic              set_hold_q_nxt;
  logic [31:0]       div_r;
  logic [31:0]       div_nxt;
  logic              tick;
  logic              load;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              osc_r;
  logic              osc_nxt;
  logic              selected;
  logic              wr_en;
  logic              rd_en;
  logic              is_clock;
  logic [2:0]        clk_idx;

  // address decode into the clock block
  function automatic logic in_clock(input logic [ADDR_W-1:0] a);
    in_clock = (a >= CLOCK_BASE);
  endfunction

  // bus mode decode from the enables
  assign selected = supply_ok && !chip_enable_n;
  assign wr_en    = selected && !write_enable_n;
  assign rd_en    = selected && write_enable_n && !output_enable_n;
  assign is_clock = in_clock(address_lines);
  assign clk_idx  = address_lines[2:0];

  // plain storage array; writes ignore output enable
  always_ff @(posedge clk_sys) begin
    if (wr_en && !is_clock) begin
      mem[address_lines] <= data_lines_in;
    end
  end

  // set-hold falling edge starts a counter load
  assign load = set_hold_q_r && !vis_r[IDX_CENTURY][SET_HOLD_BIT];
  assign set_hold_q_nxt = vis_r[IDX_CENTURY][SET_HOLD_BIT];

  // one-second divider, stopped by the oscillator-stop bit
  always_comb begin
    tick = 1'b0;
    div_nxt = div_r;
    if (vis_r[IDX_SECONDS][OSC_STOP_BIT]) begin
      div_nxt = div_r;
    end else if (div_r >= 32'(TICK_CYCLES - 1)) begin
      div_nxt = 32'h0;
      tick = 1'b1;
    end else begin
      div_nxt = div_r + 32'h1;
    end
  end
  assign osc_nxt = !vis_r[IDX_SECONDS][OSC_STOP_BIT];

  rtcc_counter u_counter (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick),
    .load     (load),
    .load_val (vis_r),
    .count    (count)
  );

  // visible copy: refresh of counter fields first, then host writes
  always_comb begin
    logic hold;
    hold = vis_r[IDX_CENTURY][SET_HOLD_BIT] || vis_r[IDX_CENTURY][READ_HOLD_BIT];
    vis_nxt = vis_r;
    if (!hold && !load) begin
      // all eight refresh together, keeping the free storage bits
      vis_nxt = (vis_r & ~COUNT_MASKS) | (count & COUNT_MASKS);
    end
    if (wr_en && is_clock) begin
      // a host write overrides the refresh in its cycle only
      vis_nxt[clk_idx] = data_lines_in;
    end
  end

  // read path: data one cycle after the request
  always_comb begin
    dout_nxt = 8'h00;
    oe_nxt   = rd_en;
    if (rd_en) begin
      dout_nxt = is_clock ? vis_r[clk_idx] : mem[address_lines];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      vis_r        <= COUNT_RESET;
      set_hold_q_r <= 1'b0;
      div_r        <= 32'h0;
      dout_r       <= 8'h00;
      oe_r         <= 1'b0;
      osc_r        <= 1'b0;
    end else begin
      vis_r        <= vis_nxt;
      set_hold_q_r <= set_hold_q_nxt;
      div_r        <= div_nxt;
      dout_r       <= dout_nxt;
      oe_r         <= oe_nxt;
      osc_r        <= osc_nxt;
    end
  end

  assign data_lines_out = dout_r;
  assign data_lines_oe  = oe_r;
  assign osc_running    = osc_r;
endmodule
`default_nettype wire

// [rtcc_top_sva.sv]
// Purpose: pin checks for rtcc_top
// Assumes: one clock, async active-high reset
// Notes:   decode follows the pin truth table
`timescale 1ns/1ps
`default_nettype none
module rtcc_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [14:0] address_lines,
  input wire logic [7:0]  data_lines_in,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe,
  input wire logic        chip_enable_n,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        supply_ok,
  input wire logic        osc_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // request decode; a fault or a high select blocks both kinds
  wire logic sel = supply_ok && !chip_enable_n;
  wire logic rd  = sel && write_enable_n && !output_enable_n;
  wire logic wr  = sel && !write_enable_n;
  sequence s_low_wr; wr && address_lines < 15'h7ff8; endsequence
  sequence s_back_rd; rd && address_lines == $past(address_lines, 2); endsequence
  sequence s_hold; wr && address_lines == 15'h7ff8 && data_lines_in[6]; endsequence
  chk_read_drive: assert property (rd |=> data_lines_oe)
    else $error("read not driven");
  chk_oe_cause: assert property (data_lines_oe |-> $past(rd))
    else $error("drive without read");
  chk_desel_quiet: assert property (chip_enable_n |=> !data_lines_oe)
    else $error("drive while deselected");
  chk_fault_quiet: assert property (!supply_ok |=> !data_lines_oe)
    else $error("drive in supply fault");
  chk_write_quiet: assert property (wr |=> !data_lines_oe)
    else $error("drive during write");
  chk_ram_store: assert property (s_low_wr ##2 s_back_rd |=> data_lines_out == $past(data_lines_in, 3))
    else $error("stored byte lost");
  chk_osc_follow: assert property (wr && address_lines == 15'h7ff9 |-> ##2 osc_running == !$past(data_lines_in[7], 2))
    else $error("oscillator state wrong");
  chk_hold_freeze: assert property (s_hold ##2 (rd && address_lines == 15'h7ff9) [*8] |=>
    data_lines_out == $past(data_lines_out, 7))
    else $error("held copy moved");
endmodule
bind rtcc_top rtcc_chk rtcc_chk_inst (.clk_sys, .reset, .address_lines, .data_lines_in, .data_lines_out,
  .data_lines_oe, .chip_enable_n, .output_enable_n, .write_enable_n, .supply_ok, .osc_running);
`default_nettype wire

// [rtcc_host.sv]
// Purpose: host driving single-byte memory cycles
// Assumes: requests change only at rising edges
// Notes:   released data lines carry the inverse byte
`timescale 1ns/1ps
`default_nettype none
module rtcc_host (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  data_lines_out,
  output var  logic [14:0] address_lines,
  output var  logic [7:0]  data_lines_in,
  output var  logic        chip_enable_n,
  output var  logic        output_enable_n,
  output var  logic        write_enable_n
);
  // idle pins at time zero
  initial begin
    {chip_enable_n, output_enable_n, write_enable_n} = 3'h7;
    address_lines = 15'h0000;
    data_lines_in = 8'h00;
  end
  // one write, taken at the second edge
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic o);
    @(posedge clk_sys);
    {chip_enable_n, write_enable_n, output_enable_n} <= {2'h0, o};
    address_lines <= a;
    data_lines_in <= d;
    @(posedge clk_sys);
    {chip_enable_n, write_enable_n, output_enable_n} <= 3'h7;
    data_lines_in <= ~d; // stale byte must not pass as data
  endtask
  // n back-to-back reads; answer sampled just after its taking edge
  task automatic rd(input logic [14:0] a, input int n, input logic o, output logic [7:0] d0, output logic [7:0] d);
    @(posedge clk_sys);
    {chip_enable_n, output_enable_n} <= {1'b0, o};
    address_lines <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (i == n - 1) {chip_enable_n, output_enable_n} <= 2'h3;
      #1;
      if (i == 0) d0 = data_lines_out;
      d = data_lines_out;
    end
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: bench for rtcc_top
// Assumes: one second shortened to TICK cycles
// Notes:   seconds read after a rollover may be 00 or 01
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TICK = 50;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic supply_ok = 1'b1;
  logic [14:0] address_lines;
  logic [7:0] data_lines_in, data_lines_out, a0, v;
  logic data_lines_oe, chip_enable_n, output_enable_n, write_enable_n, osc_running;
  int mismatches = 0;
  int checks = 0;
  // reset image, two rollover results, then the image to load
  logic [7:0] tab [4][8] = '{'{8'h60, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00},
    '{8'h60, 8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h24}, '{8'h60, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h23},
    '{8'ha0, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00}};
  rtcc_top #(.TICK_CYCLES(TICK)) rtcc_top_inst (.clk_sys, .reset, .address_lines, .data_lines_in, .data_lines_out,
    .data_lines_oe, .chip_enable_n, .output_enable_n, .write_enable_n, .supply_ok, .osc_running);
  rtcc_host host (.clk_sys, .data_lines_out, .address_lines, .data_lines_in, .chip_enable_n, .output_enable_n,
    .write_enable_n);
  initial forever #4 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // whole clock block; seconds lsb masked since a tick may land
  task automatic image(input int r);
    for (int i = 0; i < 8; i++) begin
      host.rd(15'h7ff8 + 15'(i), 1, 1'b0, a0, v);
      check("clock byte", v & ((i == 1) ? 8'hfe : 8'hff), tab[r][i]);
    end
  endtask
  // a hang ends the run here
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    host.wr(15'h7ff8, 8'h60, 1'b1);
    // burst spans at least one tick, so a copy that moved would show
    host.rd(15'h7ff9, 2 * TICK, 1'b0, a0, v);
    check("burst", v, a0);
    image(0);
    repeat (3 * TICK) @(posedge clk_sys);
    host.rd(15'h7ff9, 1, 1'b0, a0, v);
    check("held sec", v, 8'h00);
    host.wr(15'h7ff8, 8'h20, 1'b1);
    repeat (4) @(posedge clk_sys);
    host.rd(15'h7ff9, 1, 1'b0, a0, v);
    check("sec moved", 8'(v != 8'h00), 8'h01);
    // month end in a leap year and in a plain year
    for (int r = 1; r < 3; r++) begin
      for (int i = 0; i < 7; i++) host.wr(15'h7ff8 + 15'(i), tab[3][i], r[0]);
      host.wr(15'h7fff, tab[r][7], 1'b1);
      host.rd(15'h7ff9, 1, 1'b0, a0, v);
      check("loaded sec", v, 8'h59);
      host.wr(15'h7ff8, 8'h20, 1'b1);
      repeat (55) @(posedge clk_sys);
      host.wr(15'h7ff8, 8'h60, 1'b1);
      image(r);
      host.wr(15'h7ff8, 8'h20, 1'b1);
    end
    // plain storage, then a supply fault; drive enable read while it stands
    host.wr(15'h0000, 8'h5a, 1'b0);
    host.rd(15'h0000, 1, 1'b0, a0, v);
    check("low byte", v, 8'h5a);
    check("read drive", {7'h00, data_lines_oe}, 8'h01);
    host.wr(15'h7ff7, 8'ha5, 1'b1);
    host.rd(15'h7ff7, 1, 1'b1, a0, v);
    check("quiet read", v, 8'h00);
    check("quiet drive", {7'h00, data_lines_oe}, 8'h00);
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    host.wr(15'h7ff7, 8'h11, 1'b1);
    host.rd(15'h7ff7, 1, 1'b0, a0, v);
    check("fault read", v, 8'h00);
    check("fault drive", {7'h00, data_lines_oe}, 8'h00);
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    host.rd(15'h7ff7, 1, 1'b0, a0, v);
    check("kept byte", v, 8'ha5);
    // oscillator stop, then restart
    for (int k = 0; k < 2; k++) begin
      host.wr(15'h7ff9, {~k[0], 7'h00}, 1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      check("osc", {7'h00, osc_running}, {7'h00, k[0]});
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
